// ---- crs_defines.vh ----
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH
// Register select codes on the software port
`define CRS_SEL_D0 4'h0
`define CRS_SEL_D1 4'h1
`define CRS_SEL_D2 4'h2
`define CRS_SEL_D3 4'h3
`define CRS_SEL_A0 4'h4
`define CRS_SEL_A1 4'h5
`define CRS_SEL_FB 4'h6
`define CRS_SEL_PC 4'h7
`define CRS_SEL_VTB 4'h8
`define CRS_SEL_USP 4'h9
`define CRS_SEL_ISP 4'ha
`define CRS_SEL_SB 4'hb
`define CRS_SEL_FLG 4'hc
`define CRS_SEL_SP 4'hd
// Flag word bit positions
`define CRS_F_C 0
`define CRS_F_D 1
`define CRS_F_Z 2
`define CRS_F_S 3
`define CRS_F_B 4
`define CRS_F_O 5
`define CRS_F_I 6
`define CRS_F_U 7
`define CRS_F_IPL_LO 12
`define CRS_F_IPL_HI 14
`define CRS_FLG_MASK 16'h70ff
// Reset values and the last low software trap number
`define CRS_FLG_RST 16'h0000
`define CRS_PC_RST 20'h00000
`define CRS_VTB_RST 20'h00000
`define CRS_W16_RST 16'h0000
`define CRS_SWI_LAST 6'h1f
`endif

// ---- crs_bank.v ----
`timescale 1ns/10ps
`include "crs_defines.vh"
// Two banks of seven 16-bit registers; index 0-3 data, 4-5 addr, 6 frame
module crs_bank (
  clock,
  rst,
  bankSel,
  wrEn,
  wrIdx,
  wrByteEn,
  wrData,
  rdFlat
);
  input wire clock;
  input wire rst;
  input wire bankSel;
  input wire wrEn;
  input wire [2:0] wrIdx;
  input wire [1:0] wrByteEn;
  input wire [15:0] wrData;
  output wire [111:0] rdFlat;

  reg [15:0] bank0_reg [0:6];
  reg [15:0] bank1_reg [0:6];
  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1)
    begin : gReg
      always @(posedge clock or posedge rst)
      begin
        if (rst)
        begin
          bank0_reg[i] <= `CRS_W16_RST;
          bank1_reg[i] <= `CRS_W16_RST;
        end
        else if (wrEn && wrIdx == i)
        begin
          if (!bankSel)
          begin
            if (wrByteEn[0])
              bank0_reg[i][7:0] <= wrData[7:0];
            if (wrByteEn[1])
              bank0_reg[i][15:8] <= wrData[15:8];
          end
          else
          begin
            if (wrByteEn[0])
              bank1_reg[i][7:0] <= wrData[7:0];
            if (wrByteEn[1])
              bank1_reg[i][15:8] <= wrData[15:8];
          end
        end
      end
      assign rdFlat[i*16 +: 16] = bankSel ? bank1_reg[i] : bank0_reg[i];
    end
  endgenerate
endmodule

// ---- crs_register_set.v ----
`timescale 1ns/10ps
`include "crs_defines.vh"
// Behaviour
// - thirteen registers, seven banked, selected visible
// - data zero and one byte-addressable
// - data pairs form 32-bit operands
// - address regs pair into 32 bits
// - frame and static base 16 bits
// - program counter 20 bits
// - vector table base 20 bits
// - flag bit 7 picks stack pointer
// - interrupt or low software trap clears U
// - flag bit 0 captures carry
// - debug flag steps, cleared on ack
// - zero flag follows result
// - sign flag follows result
// - flag bit 4 selects bank
// - overflow flag follows result
// - interrupt enable gate, cleared on ack
// - accept only priority above level
// - flag bits 8-11, 15 reserved
module crs_register_set (
  clock,
  rst,
  regAddr,
  regWrData,
  regWrite,
  regRead,
  regRdData,
  coreWrEn,
  coreWrIdx,
  coreWrByteEn,
  coreWrData,
  pcLoad,
  pcNext,
  spLoad,
  spNext,
  aluFlagUpd,
  aluCarry,
  aluZero,
  aluSign,
  aluOverflow,
  instrDone,
  irqReq,
  irqMaskable,
  irqPriority,
  irqAck,
  stepAck,
  swiExec,
  swiNumber,
  wideDataPairLow,
  wideDataPairHigh,
  wideAddressPair,
  frameBaseOut,
  staticBaseOut,
  programCounter,
  vectorTableBase,
  stackPtrOut,
  flagWord,
  irqAccept,
  stepIrq
);
  input wire clock;
  input wire rst;
  input wire [3:0] regAddr;
  input wire [31:0] regWrData;
  input wire regWrite;
  input wire regRead;
  output reg [31:0] regRdData;
  input wire coreWrEn;
  input wire [2:0] coreWrIdx;
  input wire [1:0] coreWrByteEn;
  input wire [15:0] coreWrData;
  input wire pcLoad;
  input wire [19:0] pcNext;
  input wire spLoad;
  input wire [15:0] spNext;
  input wire aluFlagUpd;
  input wire aluCarry;
  input wire aluZero;
  input wire aluSign;
  input wire aluOverflow;
  input wire instrDone;
  input wire irqReq;
  input wire irqMaskable;
  input wire [2:0] irqPriority;
  input wire irqAck;
  input wire stepAck;
  input wire swiExec;
  input wire [5:0] swiNumber;
  output reg [31:0] wideDataPairLow;
  output reg [31:0] wideDataPairHigh;
  output reg [31:0] wideAddressPair;
  output reg [15:0] frameBaseOut;
  output reg [15:0] staticBaseOut;
  output reg [19:0] programCounter;
  output reg [19:0] vectorTableBase;
  output reg [15:0] stackPtrOut;
  output reg [15:0] flagWord;
  output reg irqAccept;
  output reg stepIrq;

  reg [15:0] flag_reg;
  reg [15:0] flag_next;
  reg [15:0] userSp_reg;
  reg [15:0] irqSp_reg;
  reg [15:0] staticBase_reg;
  reg [19:0] pc_reg;
  reg [19:0] vtb_reg;
  wire [111:0] bankRd;
  wire swWrBank;
  wire bankWrEn;
  wire [2:0] bankWrIdx;
  wire [1:0] bankWrBe;
  wire [15:0] bankWrData;
  wire flagWr;
  wire useUserSp;
  wire acceptNow;
  wire lowSwi;
  wire [15:0] d0;
  wire [15:0] d1;
  wire [15:0] d2;
  wire [15:0] d3;
  wire [15:0] a0;
  wire [15:0] a1;
  wire [15:0] fb;
  wire [15:0] activeSp;
  reg [31:0] rdMux;

  assign d0 = bankRd[15:0];
  assign d1 = bankRd[31:16];
  assign d2 = bankRd[47:32];
  assign d3 = bankRd[63:48];
  assign a0 = bankRd[79:64];
  assign a1 = bankRd[95:80];
  assign fb = bankRd[111:96];

  // Software write to a banked register takes priority over the core
  assign swWrBank = regWrite && (regAddr <= `CRS_SEL_FB);
  assign bankWrEn = swWrBank || coreWrEn;
  assign bankWrIdx = swWrBank ? regAddr[2:0] : coreWrIdx;
  assign bankWrBe = swWrBank ? 2'h3 : coreWrByteEn;
  assign bankWrData = swWrBank ? regWrData[15:0] : coreWrData;
  assign flagWr = regWrite && (regAddr == `CRS_SEL_FLG);

  crs_bank uBank (
    .clock(clock),
    .rst(rst),
    .bankSel(flag_reg[`CRS_F_B]),
    .wrEn(bankWrEn),
    .wrIdx(bankWrIdx),
    .wrByteEn(bankWrBe),
    .wrData(bankWrData),
    .rdFlat(bankRd)
  );

  assign useUserSp = flag_reg[`CRS_F_U];
  assign acceptNow = irqReq &&
    (irqPriority > flag_reg[`CRS_F_IPL_HI:`CRS_F_IPL_LO]) &&
    (!irqMaskable || flag_reg[`CRS_F_I]);
  assign lowSwi = swiExec && (swiNumber <= `CRS_SWI_LAST);

  always @*
  begin
    flag_next = flag_reg;
    if (flagWr)
      flag_next = regWrData[15:0];
    if (aluFlagUpd)
    begin
      flag_next[`CRS_F_C] = aluCarry;
      flag_next[`CRS_F_Z] = aluZero;
      flag_next[`CRS_F_S] = aluSign;
      flag_next[`CRS_F_O] = aluOverflow;
    end
    if (stepAck)
      flag_next[`CRS_F_D] = 1'b0;
    if (irqAck || stepAck)
      flag_next[`CRS_F_I] = 1'b0;
    if (irqAck || lowSwi)
      flag_next[`CRS_F_U] = 1'b0;
    flag_next = flag_next & `CRS_FLG_MASK;
  end

  assign activeSp = useUserSp ? userSp_reg : irqSp_reg;

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_reg <= `CRS_FLG_RST;
    else
      flag_reg <= flag_next;
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      pc_reg <= `CRS_PC_RST;
    else if (regWrite && regAddr == `CRS_SEL_PC)
      pc_reg <= regWrData[19:0];
    else if (pcLoad)
      pc_reg <= pcNext;
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      vtb_reg <= `CRS_VTB_RST;
    else if (regWrite && regAddr == `CRS_SEL_VTB)
      vtb_reg <= regWrData[19:0];
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      staticBase_reg <= `CRS_W16_RST;
    else if (regWrite && regAddr == `CRS_SEL_SB)
      staticBase_reg <= regWrData[15:0];
  end

  // Software write beats a same-cycle core push or pop
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      userSp_reg <= `CRS_W16_RST;
    else if (regWrite && regAddr == `CRS_SEL_USP)
      userSp_reg <= regWrData[15:0];
    else if (spLoad && useUserSp)
      userSp_reg <= spNext;
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
      irqSp_reg <= `CRS_W16_RST;
    else if (regWrite && regAddr == `CRS_SEL_ISP)
      irqSp_reg <= regWrData[15:0];
    else if (spLoad && !useUserSp)
      irqSp_reg <= spNext;
  end

  // Unmapped selects read as zero
  always @*
  begin
    rdMux = 32'h00000000;
    case (regAddr)
      `CRS_SEL_D0: rdMux = {16'h0000, d0};
      `CRS_SEL_D1: rdMux = {16'h0000, d1};
      `CRS_SEL_D2: rdMux = {16'h0000, d2};
      `CRS_SEL_D3: rdMux = {16'h0000, d3};
      `CRS_SEL_A0: rdMux = {16'h0000, a0};
      `CRS_SEL_A1: rdMux = {16'h0000, a1};
      `CRS_SEL_FB: rdMux = {16'h0000, fb};
      `CRS_SEL_PC: rdMux = {12'h000, pc_reg};
      `CRS_SEL_VTB: rdMux = {12'h000, vtb_reg};
      `CRS_SEL_USP: rdMux = {16'h0000, userSp_reg};
      `CRS_SEL_ISP: rdMux = {16'h0000, irqSp_reg};
      `CRS_SEL_SB: rdMux = {16'h0000, staticBase_reg};
      `CRS_SEL_FLG: rdMux = {16'h0000, flag_reg};
      `CRS_SEL_SP: rdMux = {16'h0000, activeSp};
      default: rdMux = 32'h00000000;
    endcase
  end

  // Outputs registered; they lag the state by one cycle
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      wideDataPairLow <= 32'h00000000;
      wideDataPairHigh <= 32'h00000000;
      wideAddressPair <= 32'h00000000;
      frameBaseOut <= `CRS_W16_RST;
    end
    else
    begin
      wideDataPairLow <= {d2, d0};
      wideDataPairHigh <= {d3, d1};
      wideAddressPair <= {a1, a0};
      frameBaseOut <= fb;
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      staticBaseOut <= `CRS_W16_RST;
      programCounter <= `CRS_PC_RST;
      vectorTableBase <= `CRS_VTB_RST;
      stackPtrOut <= `CRS_W16_RST;
      flagWord <= `CRS_FLG_RST;
    end
    else
    begin
      staticBaseOut <= staticBase_reg;
      programCounter <= pc_reg;
      vectorTableBase <= vtb_reg;
      stackPtrOut <= activeSp;
      flagWord <= flag_reg;
    end
  end

  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      irqAccept <= 1'b0;
      stepIrq <= 1'b0;
    end
    else
    begin
      irqAccept <= acceptNow;
      stepIrq <= instrDone && flag_reg[`CRS_F_D];
    end
  end

  // Read data stands one cycle only, zero otherwise
  always @(posedge clock or posedge rst)
  begin
    if (rst)
      regRdData <= 32'h00000000;
    else if (regRead)
      regRdData <= rdMux;
    else
      regRdData <= 32'h00000000;
  end
endmodule

// ---- crs_alu_model.sv ----
`timescale 1ns/10ps
module crs_alu_model (
  input wire clock,
  input wire aluGo,
  input wire [15:0] aluA,
  input wire [15:0] aluB,
  output logic aluFlagUpd = 1'h0,
  output logic aluCarry = 1'h0,
  output logic aluZero = 1'h0,
  output logic aluSign = 1'h0,
  output logic aluOverflow = 1'h0
);
  wire [16:0] sum = aluA + aluB;
  // Add only; enough to reach every flag
  always @(posedge clock)
  begin
    aluFlagUpd <= aluGo;
    aluCarry <= sum[16];
    aluZero <= sum[15:0] == 16'h0;
    aluSign <= sum[15];
    aluOverflow <= aluA[15] == aluB[15] && sum[15] != aluA[15];
  end
endmodule

// ---- crs_register_set_asserts.sv ----
`timescale 1ns/10ps
module crs_asserts (
  input wire clock,
  input wire rst,
  input wire aluFlagUpd,
  input wire aluCarry,
  input wire aluZero,
  input wire aluSign,
  input wire aluOverflow,
  input wire instrDone,
  input wire irqReq,
  input wire irqMaskable,
  input wire [2:0] irqPriority,
  input wire irqAck,
  input wire stepAck,
  input wire swiExec,
  input wire [5:0] swiNumber,
  input wire [15:0] flagWord,
  input wire irqAccept,
  input wire stepIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  wire [2:0] lvl = flagWord[14:12];
  prio_gate_a:
  assert property (!$past(rst) |-> irqAccept == ($past(irqReq) &&
    $past(irqPriority) > lvl && (!$past(irqMaskable) || flagWord[6])))
    else $error("bad accept");
  step_pulse_a:
  assert property (!$past(rst) |-> stepIrq == ($past(instrDone) &&
    flagWord[1])) else $error("bad step");
  ack_clear_a:
  assert property (irqAck |-> ##2 flagWord[7:6] == 2'h0)
    else $error("ack kept flags");
  step_ack_a:
  assert property (stepAck |-> ##2 !flagWord[1]) else $error("debug kept");
  swi_low_a:
  assert property (swiExec && swiNumber <= 6'h1f |-> ##2 !flagWord[7])
    else $error("trap kept stack flag");
  rsvd_zero_a:
  assert property (flagWord[11:8] == 4'h0 && !flagWord[15])
    else $error("reserved set");
  carry_zero_a:
  assert property (aluFlagUpd |-> ##2 flagWord[0] == $past(aluCarry, 2)
    && flagWord[2] == $past(aluZero, 2)) else $error("bad carry or zero");
  sign_ovf_a:
  assert property (aluFlagUpd |-> ##2 {flagWord[5], flagWord[3]} ==
    $past({aluOverflow, aluSign}, 2)) else $error("bad sign or overflow");
  cover property (irqAccept);
  cover property (stepIrq);
  cover property (swiExec && swiNumber > 6'h1f);
endmodule
bind crs_register_set crs_asserts i_crs_asserts (.clock, .rst, .aluFlagUpd,
  .aluCarry, .aluZero, .aluSign, .aluOverflow, .instrDone, .irqReq,
  .irqMaskable, .irqPriority, .irqAck, .stepAck, .swiExec, .swiNumber,
  .flagWord, .irqAccept, .stepIrq);

// ---- crs_register_set_bench.sv ----
`timescale 1ns/10ps
`include "crs_defines.vh"
module crs_register_set_bench;
  logic clock = 1'h0, rst = 1'h1, regWrite = 1'h0, regRead = 1'h0;
  logic irqReq = 1'h0, irqMaskable = 1'h0, pcLoad = 1'h0, spLoad = 1'h0;
  logic [19:0] pcNext = 20'h0;
  logic [15:0] spNext = 16'h0;
  wire [31:0] wideDataPairHigh;
  wire [15:0] frameBaseOut, staticBaseOut, stackPtrOut;
  wire [19:0] programCounter, vectorTableBase;
  logic [5:0] st = 6'h0, swiNumber = 6'h0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic [2:0] coreWrIdx = 3'h0, irqPriority = 3'h0;
  logic [1:0] coreWrByteEn = 2'h0;
  logic [15:0] coreWrData = 16'h0, aluA = 16'h0, aluB = 16'h1;
  wire instrDone = st[0], irqAck = st[1], stepAck = st[2];
  wire swiExec = st[3], coreWrEn = st[4], aluGo = st[5];
  wire aluFlagUpd, aluCarry, aluZero, aluSign, aluOverflow;
  wire irqAccept, stepIrq;
  wire [31:0] regRdData, wideDataPairLow, wideAddressPair;
  wire [15:0] flagWord;
  int fail_count = 0, check_count = 0;
  logic [3:0] sel [4] = '{4'h7, 4'h8, 4'hb, 4'h6};
  logic [31:0] msk [4] = '{32'hfffff, 32'hfffff, 32'hffff, 32'hffff};
  crs_alu_model i_crs_alu_model (.clock, .aluGo, .aluA, .aluB, .aluFlagUpd,
    .aluCarry, .aluZero, .aluSign, .aluOverflow);
  crs_register_set i_crs_register_set (.clock, .rst, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .coreWrEn, .coreWrIdx, .coreWrByteEn,
    .coreWrData, .pcLoad, .pcNext, .spLoad,
    .spNext, .aluFlagUpd, .aluCarry, .aluZero, .aluSign,
    .aluOverflow, .instrDone, .irqReq, .irqMaskable, .irqPriority, .irqAck,
    .stepAck, .swiExec, .swiNumber, .wideDataPairLow,
    .wideDataPairHigh, .wideAddressPair, .frameBaseOut,
    .staticBaseOut, .programCounter, .vectorTableBase,
    .stackPtrOut, .flagWord, .irqAccept, .stepIrq);
  always #12.5 clock = ~clock;
  task close_out;
    $display("checks %0d failures %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task pulse(input logic [5:0] s);
    @(posedge clock);
    st <= s;
    @(posedge clock);
    st <= 6'h0;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'h1;
    @(posedge clock);
    regWrite <= 1'h0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'h1;
    @(posedge clock);
    regRead <= 1'h0;
    #1 chk(regRdData, e);
  endtask
  task cw(input logic [2:0] i, input logic [1:0] b, input logic [15:0] d);
    coreWrIdx <= i;
    coreWrByteEn <= b;
    coreWrData <= d;
    pulse(6'h10);
  endtask
  // Sequence never waits on the design; this only guards a stall
  initial #400000 begin fail_count++; close_out; end
  initial
  begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    rd(`CRS_SEL_FLG, 32'h0);
    rd(4'he, 32'h0);
    wr(`CRS_SEL_FLG, 32'hffffffff);
    rd(`CRS_SEL_FLG, 32'h70ff);
    wr(`CRS_SEL_FLG, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(sel[i], 32'hffffffff);
      rd(sel[i], msk[i]);
    end
    chk(programCounter, 32'hfffff);
    chk(vectorTableBase, 32'hfffff);
    chk(staticBaseOut, 32'hffff);
    pcNext <= 20'h12345;
    pcLoad <= 1'h1;
    @(posedge clock);
    pcLoad <= 1'h0;
    rd(`CRS_SEL_PC, 32'h12345);
    wr(`CRS_SEL_D0, 32'h1111);
    wr(`CRS_SEL_FLG, 32'h10);
    wr(`CRS_SEL_D0, 32'h2222);
    rd(`CRS_SEL_D0, 32'h2222);
    wr(`CRS_SEL_FLG, 32'h0);
    rd(`CRS_SEL_D0, 32'h1111);
    $display("register test done");
    cw(3'h0, 2'h1, 16'hab55);
    cw(3'h0, 2'h2, 16'h77cd);
    cw(3'h2, 2'h3, 16'h2020);
    cw(3'h4, 2'h3, 16'h0a0a);
    cw(3'h5, 2'h3, 16'h1b1b);
    cw(3'h1, 2'h3, 16'h4c4c);
    cw(3'h3, 2'h3, 16'h3d3d);
    @(posedge clock);
    #1 chk(wideDataPairLow, 32'h20207755);
    chk(wideDataPairHigh, 32'h3d3d4c4c);
    chk(frameBaseOut, 32'hffff);
    chk(wideAddressPair, 32'h1b1b0a0a);
    rd(`CRS_SEL_D0, 32'h7755);
    $display("core test done");
    wr(`CRS_SEL_USP, 32'h1234);
    wr(`CRS_SEL_ISP, 32'h5678);
    rd(`CRS_SEL_SP, 32'h5678);
    wr(`CRS_SEL_FLG, 32'h80);
    rd(`CRS_SEL_SP, 32'h1234);
    spNext <= 16'h9abc;
    spLoad <= 1'h1;
    @(posedge clock);
    spLoad <= 1'h0;
    rd(`CRS_SEL_USP, 32'h9abc);
    chk(stackPtrOut, 32'h9abc);
    rd(`CRS_SEL_ISP, 32'h5678);
    swiNumber <= 6'h20;
    pulse(6'h08);
    rd(`CRS_SEL_FLG, 32'h80);
    swiNumber <= 6'h1f;
    pulse(6'h08);
    rd(`CRS_SEL_FLG, 32'h0);
    wr(`CRS_SEL_FLG, 32'hc0);
    pulse(6'h02);
    rd(`CRS_SEL_FLG, 32'h0);
    aluA <= 16'hffff;
    pulse(6'h20);
    rd(`CRS_SEL_FLG, 32'h5);
    aluA <= 16'h7fff;
    pulse(6'h20);
    rd(`CRS_SEL_FLG, 32'h28);
    wr(`CRS_SEL_FLG, 32'h42);
    pulse(6'h01);
    #1 chk(stepIrq, 1'h1);
    pulse(6'h04);
    rd(`CRS_SEL_FLG, 32'h0);
    $display("flag test done");
    wr(`CRS_SEL_FLG, 32'h3040);
    irqMaskable <= 1'h1;
    irqReq <= 1'h1;
    for (int p = 0; p < 8; p++)
    begin
      irqPriority <= p[2:0];
      @(posedge clock);
      #1 chk(irqAccept, p > 3);
    end
    wr(`CRS_SEL_FLG, 32'h3000);
    @(posedge clock);
    #1 chk(irqAccept, 1'h0);
    irqMaskable <= 1'h0;
    @(posedge clock);
    #1 chk(irqAccept, 1'h1);
    $display("priority test done");
    close_out;
  end
endmodule
